// *** inc/fifo_pkg.sv ***
// Constants and carrier types for the dual-clock FIFO flag logic.
// Assumes one system clock; both FIFO clocks arrive as sampled pins.
package fifo_pkg;

   localparam int word_w = 18;
   localparam int addr_w = 16;
   localparam int cnt_w = addr_w + 1;
   localparam int offset_w = 16;

   typedef logic [word_w-1:0] word_t;
   typedef logic [cnt_w-1:0] cnt_t;
   typedef logic [offset_w-1:0] offset_t;

   // Memory depth and the half-full level (depth / 2 + 1)
   localparam cnt_t depth = 17'h10000;
   localparam cnt_t half_level = 17'h08001;

   // Default offsets chosen at master reset by the load strap
   localparam offset_t offset_serial_default = 16'h03FF;
   localparam offset_t offset_parallel_default = 16'h007F;

   // Cycles after reset release before the straps are sampled
   localparam logic [1:0] strap_settle = 2'h2;

   // Pins sampled from outside the clock domain
   typedef struct packed {
      logic wclk;
      logic rclk;
      logic write_en_n;
      logic read_en_n;
      logic mode_select_serial_in;
      logic offset_load_n;
      word_t data;
   } pin_s;

   localparam int pin_w = $bits(pin_s);

   typedef struct packed {
      offset_t empty_offset;
      offset_t full_offset;
   } offsets_s;

endpackage

// *** hdl/pin_sync.sv ***
// Two-stage synchroniser for a bundle of asynchronous pins.
// Assumes every bit is sampled independently; no bundle coherency.
module pin_sync #(
   parameter int width = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Pins in, synchronised out
   input wire logic [width-1:0] async_in,
   output logic [width-1:0] sync_out
);

   logic [width-1:0] stage1;

   genvar i;
   generate
      for (i = 0; i < width; i++) begin : g_bit
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               stage1[i] <= 1'b0;
               sync_out[i] <= 1'b0;
            end else begin
               stage1[i] <= async_in[i];
               sync_out[i] <= stage1[i];
            end
         end
      end
   endgenerate

endmodule

// *** hdl/dual_clock_fifo.sv ***
// Dual-clock FIFO, 65,536 x 18, with standard and fall-through flags.
// Assumes write and read clocks far slower than clk; edges are found
// by sampling. Write-side and read-side state advance only on edges.
//
// Operation
// - Mode strap caught at master reset: low standard, high fall-through.
// - Standard mode: every word, first included, needs a read enable.
// - Fall-through: first word reaches outputs after three read edges.
// - Data stored on each write clock edge with write enable low and memory not full.
// - Standard: empty flag rises once the first word is written.
// - Standard: almost-empty high at n+1 words or more, low at n.
// - Standard: half-full low from depth/2+1 words.
// - Standard: almost-full low from depth minus m words.
// - Standard: full flag low at depth, blocks writes; one read lifts it.
// - Standard: almost-empty falls when draining reaches n words.
// - Standard: empty flag low after last read; reads then ignored.
// - Fall-through: output ready low after first write into empty FIFO.
// - Fall-through: almost-empty high once n+2 words are held.
// - Fall-through: half-full low from depth/2+2 words.
// - Fall-through: almost-full low from depth+1-m words.
// - Fall-through: input ready high at depth+1 words, blocks writes.
// - Fall-through: almost-empty falls when n+1 words remain.
// - Fall-through: output ready high after last read; reads ignored.
// - Empty/full flags two stages; output ready three stages.
// - Load strap high: serial loading, both offsets default 3FF.
// - Load strap low: parallel loading, both offsets default 07F.
// - Offsets readable only in parallel method; writable in either method once straps are caught.
module dual_clock_fifo
   import fifo_pkg::*;
(
   // System
   input wire logic clk,
   input wire logic rstn,
   // Write side pins
   input wire logic wclk,
   input wire logic write_en_n,
   input wire word_t data_in,
   // Read side pins
   input wire logic rclk,
   input wire logic read_en_n,
   // Straps sampled at master reset
   input wire logic mode_select_serial_in,
   input wire logic offset_load_n,
   // Offset programming, same clock domain
   input wire logic offset_write,
   input wire offsets_s offset_in,
   // Data and status
   output word_t data_out,
   output logic empty_flag_n,
   output logic output_ready_n,
   output logic full_flag_n,
   output logic input_ready_n,
   output logic almost_empty_n,
   output logic almost_full_n,
   output logic half_full_n,
   // Mode and offset readback
   output logic fall_through_mode,
   output logic serial_load,
   output logic ready,
   output offsets_s offset_readback
);

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisation and edge finding

   pin_s pin_raw;
   pin_s pin;
   logic wclk_d;
   logic rclk_d;
   logic wr_edge;
   logic rd_edge;

   assign pin_raw = '{
      wclk: wclk,
      rclk: rclk,
      write_en_n: write_en_n,
      read_en_n: read_en_n,
      mode_select_serial_in: mode_select_serial_in,
      offset_load_n: offset_load_n,
      data: data_in
   };

   pin_sync #(
      .width(pin_w)
   ) u_pin_sync (
      .clk(clk),
      .rstn(rstn),
      .async_in(pin_raw),
      .sync_out(pin)
   );

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wclk_d <= 1'b0;
         rclk_d <= 1'b0;
      end else begin
         wclk_d <= pin.wclk;
         rclk_d <= pin.rclk;
      end
   end

   // No edge counts until the straps are caught
   assign wr_edge = ready & pin.wclk & ~wclk_d;
   assign rd_edge = ready & pin.rclk & ~rclk_d;

   ////////////////////////////////////////////////////////////////////
   // Straps and offsets

   logic [1:0] settle;
   logic strap_now;
   offsets_s offsets;

   assign strap_now = !ready && (settle == strap_settle);

   // Straps caught after the synchroniser has filled, not under reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         settle <= 2'h0;
         ready <= 1'b0;
         fall_through_mode <= 1'b0;
         serial_load <= 1'b0;
      end else if (strap_now) begin
         ready <= 1'b1;
         fall_through_mode <= pin.mode_select_serial_in;
         serial_load <= pin.offset_load_n;
      end else if (!ready) begin
         settle <= settle + 2'h1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         offsets <= '{offset_parallel_default, offset_parallel_default};
      end else if (strap_now) begin
         if (pin.offset_load_n) begin
            offsets <= '{offset_serial_default,
                         offset_serial_default};
         end else begin
            offsets <= '{offset_parallel_default,
                         offset_parallel_default};
         end
      end else if (ready && offset_write) begin
         offsets <= offset_in;
      end
   end

   // Serial method gives no readback path
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         offset_readback <= '0;
      end else if (ready && !serial_load) begin
         offset_readback <= offsets;
      end else begin
         offset_readback <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Write side: pointer, synchronised read pointer, memory

   word_t mem [0:(1 << addr_w) - 1];
   cnt_t wp;
   cnt_t rp;
   cnt_t rp_w1;
   cnt_t rp_w2;
   cnt_t wcount;
   cnt_t next_wcount;
   cnt_t full_level;
   logic do_write;

   assign wcount = wp - rp_w2;
   // Memory full also covers input ready; output register is the +1
   assign do_write = wr_edge & ~pin.write_en_n
                   & (wcount != depth);
   assign next_wcount = wp + cnt_t'(do_write) - rp_w1;
   assign full_level = depth - cnt_t'(offsets.full_offset);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wp <= '0;
         rp_w1 <= '0;
         rp_w2 <= '0;
      end else if (wr_edge) begin
         rp_w1 <= rp;
         rp_w2 <= rp_w1;
         if (do_write) begin
            wp <= wp + cnt_t'(1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (do_write) begin
         mem[wp[addr_w-1:0]] <= pin.data;
      end
   end

   // Write-side flags; the +1 of fall-through lives in the out register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         full_flag_n <= 1'b1;
         input_ready_n <= 1'b0;
         half_full_n <= 1'b1;
         almost_full_n <= 1'b1;
      end else if (wr_edge) begin
         // Read pointer reaches here over two write edges
         full_flag_n <= fall_through_mode
                      | (next_wcount != depth);
         input_ready_n <= fall_through_mode
                        & (next_wcount == depth);
         half_full_n <= !(next_wcount >= half_level);
         almost_full_n <= !(next_wcount >= full_level);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read side: pointer, synchronised write pointer, output register

   cnt_t wp_r1;
   cnt_t wp_r2;
   cnt_t rcount;
   cnt_t next_rp;
   cnt_t next_mem;
   cnt_t next_total;
   cnt_t empty_level;
   logic out_valid;
   logic next_valid;
   logic std_read;
   logic ft_pop;
   logic ft_load;

   assign rcount = wp_r2 - rp;
   // Reads on an empty FIFO are dropped
   assign std_read = rd_edge & ~fall_through_mode & ~pin.read_en_n
                   & (rcount != '0);
   assign ft_pop = rd_edge & fall_through_mode & ~pin.read_en_n
                 & out_valid;
   // Out register refills without a read enable when it is empty
   assign ft_load = rd_edge & fall_through_mode & (rcount != '0)
                  & (~out_valid | ft_pop);
   assign next_rp = rp + cnt_t'(std_read | ft_load);
   assign next_valid = ft_load | (out_valid & ~ft_pop);
   assign next_mem = wp_r1 - next_rp;
   assign next_total = next_mem + cnt_t'(fall_through_mode & next_valid);
   assign empty_level = cnt_t'(offsets.empty_offset)
                      + cnt_t'(fall_through_mode);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wp_r1 <= '0;
         wp_r2 <= '0;
         rp <= '0;
         out_valid <= 1'b0;
      end else if (rd_edge) begin
         wp_r1 <= wp;
         wp_r2 <= wp_r1;
         rp <= next_rp;
         out_valid <= next_valid;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         data_out <= '0;
      end else if (std_read || ft_load) begin
         data_out <= mem[rp[addr_w-1:0]];
      end
   end

   // Read-side flags; write pointer needs two read edges to arrive
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         empty_flag_n <= 1'b0;
         output_ready_n <= 1'b1;
         almost_empty_n <= 1'b0;
      end else if (rd_edge) begin
         empty_flag_n <= !fall_through_mode
                       & (next_mem != '0);
         output_ready_n <= !(fall_through_mode
                           & next_valid);
         // Threshold is n in standard, n+1 in fall-through
         almost_empty_n <= next_total
                         > empty_level;
      end
   end

endmodule

// *** testbench/fifo_flag_properties.sv ***
// Checker for the mode, offset and flag ports of the FIFO.
// Assumes straps are held through reset; bound into every instance.
module fifo_flag_properties
   import fifo_pkg::*;
(
   // System
   input wire logic clk,
   input wire logic rstn,
   // Offset port
   input wire logic offset_write,
   input wire offsets_s offset_in,
   // Status
   input wire word_t data_out,
   input wire logic empty_flag_n,
   input wire logic output_ready_n,
   input wire logic full_flag_n,
   input wire logic input_ready_n,
   input wire logic almost_full_n,
   input wire logic half_full_n,
   input wire logic fall_through_mode,
   input wire logic serial_load,
   input wire logic ready,
   input wire offsets_s offset_readback
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rstn);

   mode_hold_a: assert property (
      ready && $past(ready) |-> $stable(fall_through_mode))
      else $error("mode moved after strap catch");
   std_idle_a: assert property (
      ready && !fall_through_mode |-> output_ready_n && !input_ready_n)
      else $error("fall-through flags active in standard mode");
   ft_idle_a: assert property (
      ready && fall_through_mode |-> !empty_flag_n && full_flag_n)
      else $error("standard flags active in fall-through mode");
   serial_rb_a: assert property (
      ready && serial_load |-> offset_readback == 32'h00000000)
      else $error("offsets readable in serial method");
   parallel_dflt_a: assert property (
      $rose(ready) && !serial_load && !offset_write
      |-> ##[1:3] offset_readback == 32'h007F007F)
      else $error("parallel default offsets wrong");
   rb_write_a: assert property (
      ready && !serial_load && offset_write
      |-> ##2 offset_readback == $past(offset_in, 2))
      else $error("written offsets not read back");
   std_empty_a: assert property (
      !fall_through_mode && !empty_flag_n && !$past(empty_flag_n)
      |-> $stable(data_out))
      else $error("data moved while empty");
   ft_empty_a: assert property (
      fall_through_mode && output_ready_n && $past(output_ready_n)
      |-> $stable(data_out))
      else $error("data moved without output ready");
   full_flags_a: assert property (
      !full_flag_n |-> !almost_full_n && !half_full_n)
      else $error("full without partial flags");
   ir_flags_a: assert property (
      fall_through_mode && input_ready_n |-> !almost_full_n && !half_full_n)
      else $error("input blocked without partial flags");
endmodule

bind dual_clock_fifo fifo_flag_properties u_fifo_flag_properties (
   .clk, .rstn, .offset_write, .offset_in, .data_out, .empty_flag_n,
   .output_ready_n, .full_flag_n, .input_ready_n, .almost_full_n,
   .half_full_n, .fall_through_mode, .serial_load, .ready,
   .offset_readback
);

// *** testbench/far_side.sv ***
// Writer and reader on the far side, making the FIFO clock pins.
// Assumes clk of 50 ns; one call is one 400 ns link period.
module far_side
   import fifo_pkg::*;
(
   // Pacing clock
   input wire logic clk,
   // Pins towards the FIFO
   output logic wclk,
   output logic rclk,
   output logic write_en_n,
   output logic read_en_n,
   output word_t data_in
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      wclk = 1'b0;
      rclk = 1'b0;
      write_en_n = 1'b1;
      read_en_n = 1'b1;
      data_in = 18'h00000;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Clocks stand still between calls; released data shows inverse
   task automatic cyc(input logic w, input logic r, input logic wen_n,
         input logic ren_n, input word_t d);
      write_en_n = wen_n;
      read_en_n = ren_n;
      data_in = d;
      tick(2);
      wclk = w;
      tick(2);
      rclk = r;
      tick(1);
      write_en_n = 1'b1;
      read_en_n = 1'b1;
      data_in = ~d;
      tick(1);
      wclk = 1'b0;
      tick(2);
      rclk = 1'b0;
   endtask
endmodule

// *** testbench/dual_clock_fifo_flag_modes_tb.sv ***
// Bench for the FIFO flags in standard and fall-through modes.
// Assumes the far side model paces pins at 400 ns periods.
module dual_clock_fifo_flag_modes_tb
   import fifo_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rstn, wclk, rclk, write_en_n, read_en_n;
   logic mode_select_serial_in, offset_load_n, offset_write;
   logic empty_flag_n, output_ready_n, full_flag_n, input_ready_n;
   logic almost_empty_n, almost_full_n, half_full_n;
   logic fall_through_mode, serial_load, ready;
   word_t data_in, data_out;
   offsets_s offset_in, offset_readback;
   int mismatches, n_tests, cycles;

   dual_clock_fifo u_dual_clock_fifo (.clk, .rstn, .wclk, .write_en_n,
      .data_in, .rclk, .read_en_n, .mode_select_serial_in,
      .offset_load_n, .offset_write, .offset_in, .data_out,
      .empty_flag_n, .output_ready_n, .full_flag_n, .input_ready_n,
      .almost_empty_n, .almost_full_n, .half_full_n,
      .fall_through_mode, .serial_load, .ready, .offset_readback);
   far_side u_far_side (.clk, .wclk, .rclk, .write_en_n, .read_en_n,
      .data_in);

   always #25 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         close_out();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Straps stay put until the next reset, well past the catch
   task automatic restart(input logic mode, input logic load);
      rstn = 1'b0;
      mode_select_serial_in = mode;
      offset_load_n = load;
      tick(3);
      rstn = 1'b1;
      tick(6);
   endtask
   task automatic wr(input word_t d);
      u_far_side.cyc(1'b1, 1'b0, 1'b0, 1'b1, d);
   endtask
   task automatic wrr(input word_t d);
      u_far_side.cyc(1'b1, 1'b1, 1'b0, 1'b1, d);
   endtask
   task automatic rd();
      u_far_side.cyc(1'b0, 1'b1, 1'b1, 1'b0, 18'h00000);
      tick(3);
   endtask
   task automatic idle(input int n);
      repeat (n) u_far_side.cyc(1'b0, 1'b1, 1'b1, 1'b1, 18'h00000);
      tick(3);
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      offset_write = 1'b0;
      offset_in = 32'h00000000;
      restart(1'b0, 1'b0);
      chk({ready, fall_through_mode, serial_load}, 3'h4);
      chk(offset_readback, 32'h007F007F);
      offset_in = 32'h0002FFF0;
      offset_write = 1'b1;
      tick(1);
      offset_write = 1'b0;
      tick(3);
      chk(offset_readback, 32'h0002FFF0);
      for (int i = 0; i < 3; i++) begin
         wr(18'h00100 + 18'(i));
      end
      idle(2);
      chk(empty_flag_n, 1'b1);
      chk(almost_empty_n, 1'b1);
      chk(data_out, 18'h00000);
      rd();
      chk(data_out, 18'h00100);
      chk(almost_empty_n, 1'b0);
      rd();
      rd();
      chk(empty_flag_n, 1'b0);
      rd();
      chk(data_out, 18'h00102);
      for (int i = 1; i <= 16; i++) begin
         wr(18'(i));
         tick(1);
         if (i >= 15) chk(almost_full_n, i < 16);
      end
      $display("standard mode test done");
      restart(1'b1, 1'b1);
      chk({ready, fall_through_mode, serial_load}, 3'h7);
      chk(offset_readback, 32'h00000000);
      wr(18'h002AA);
      idle(2);
      chk(output_ready_n, 1'b1);
      idle(1);
      chk(data_out, 18'h002AA);
      chk(output_ready_n, 1'b0);
      rd();
      chk(output_ready_n, 1'b1);
      for (int i = 0; i < 1024; i++) begin
         wrr(18'(i));
      end
      idle(3);
      chk(almost_empty_n, 1'b0);
      wr(18'h00400);
      idle(3);
      chk(almost_empty_n, 1'b1);
      rd();
      chk(data_out, 18'h00001);
      chk(almost_empty_n, 1'b0);
      $display("fall-through mode test done");
      close_out();
   end
endmodule
